// >>> logic/bpas_top.sv
// beam position analog scaler with apb register access
`timescale 1ns/1ps
`include "bpas_consts.svh"

// What this block does
// - top mode follows highest interrupted beam
// - bottom mode follows lowest interrupted beam
// - size mode follows interrupted beam count
// - full teach stores value for maximum code
// - zero teach stores value for minimum code
// - free web edge taught anywhere gives midscale
// - top entering web edge gives midscale
// - free web edge: top and bottom shifts move output oppositely
// - mid teach stores web edge reference
// - endpoint trims only after position teach
// - signed step trims only after web teach
// - range select picks voltage or current span
// - mode chosen by up down, enter commits
// - blanked beams ignored in evaluation
module bpas_top #(
    parameter int NBEAMS = 32,
    parameter int VW     = 6,
    parameter int SW     = 16
) (
    input  wire logic               mclk_i,
    input  wire logic               reset_i,
    input  wire logic               ce_i,
    input  wire logic               psel_i,
    input  wire logic               penable_i,
    input  wire logic               pwrite_i,
    input  wire logic [7:0]         paddr_i,
    input  wire logic [31:0]        pwdata_i,
    output logic [31:0]             prdata_o,
    output logic                    pready_o,
    output logic                    pslverr_o,
    input  wire logic [NBEAMS-1:0]  beams_i,
    output logic [11:0]             analog_code_o,
    output logic                    range_current_o,
    output bpas_pkg::bpas_mode_t    mode_o
);
    import bpas_pkg::*;

    localparam int CW = `BPAS_CODE_W;
    localparam int NW = VW + CW;

    // ************************************************************
    // address decode
    // ************************************************************
    function automatic logic hit(input logic [7:0] a);
        case (a)
            `BPAS_OFS_CTRL, `BPAS_OFS_CMD, `BPAS_OFS_BLANK,
            `BPAS_OFS_LOW, `BPAS_OFS_HIGH, `BPAS_OFS_STEP,
            `BPAS_OFS_REF, `BPAS_OFS_STATUS,
            `BPAS_OFS_CODE: hit = 1'b1;
            default:        hit = 1'b0;
        endcase
    endfunction : hit

    function automatic logic [VW-1:0] mag(input logic [VW:0] v);
        logic [VW:0] n;
        n   = v[VW] ? (~v + 1'b1) : v;
        mag = n[VW-1:0];
    endfunction : mag

    logic              rd_ok_reg;
    logic              wr_en;
    logic [31:0]       rd_word;
    logic [31:0]       cmd;
    logic [2:0]        ctrl_reg;
    logic [NBEAMS-1:0] blank_reg;
    bpas_mode_t        mode_reg;
    bpas_mode_t        cand_reg;
    logic              pos_taught_reg;
    logic              web_taught_reg;
    logic [VW-1:0]     low_reg;
    logic [VW-1:0]     high_reg;
    logic [VW-1:0]     ref_top_reg;
    logic [VW-1:0]     ref_bot_reg;
    logic signed [SW-1:0] step_reg;
    logic [CW-1:0]     pos_code_reg;
    logic [CW-1:0]     code_reg;
    logic [31:0]       prdata_reg;

    bpas_eval_if #(.VW(VW)) ev ();

    // ************************************************************
    // apb slave
    // ************************************************************
    assign pready_o  = ce_i & psel_i & penable_i & (pwrite_i | rd_ok_reg);
    assign pslverr_o = pready_o & ~hit(paddr_i);
    assign wr_en     = pready_o & pwrite_i & hit(paddr_i);
    assign cmd       = (wr_en && paddr_i == `BPAS_OFS_CMD) ?
                       pwdata_i : 32'h0000_0000;
    assign prdata_o  = prdata_reg;

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            rd_ok_reg  <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else if (ce_i) begin
            rd_ok_reg <= psel_i & ~pwrite_i & ~pready_o;
            if (psel_i && !pwrite_i) begin
                prdata_reg <= hit(paddr_i) ? rd_word : 32'h0000_0000;
            end
        end
    end

    always_comb begin
        rd_word = 32'h0000_0000;
        case (paddr_i)
            `BPAS_OFS_CTRL:  rd_word[2:0] = ctrl_reg;
            `BPAS_OFS_BLANK: rd_word[NBEAMS-1:0] = blank_reg;
            `BPAS_OFS_LOW:   rd_word[VW-1:0] = low_reg;
            `BPAS_OFS_HIGH:  rd_word[VW-1:0] = high_reg;
            `BPAS_OFS_STEP:  rd_word[SW-1:0] = step_reg;
            `BPAS_OFS_REF: begin
                rd_word[VW-1:0]     = ref_top_reg;
                rd_word[VW+15:16]   = ref_bot_reg;
            end
            `BPAS_OFS_STATUS: begin
                rd_word[1:0]        = mode_reg;
                rd_word[3:2]        = cand_reg;
                rd_word[4]          = pos_taught_reg;
                rd_word[5]          = web_taught_reg;
                rd_word[6]          = ev.any;
                rd_word[VW+7:8]     = ev.count;
                rd_word[VW+15:16]   = ev.top_idx;
                rd_word[VW+23:24]   = ev.bot_idx;
            end
            `BPAS_OFS_CODE:  rd_word[CW-1:0] = code_reg;
            default:         rd_word = 32'h0000_0000;
        endcase
    end

    // ************************************************************
    // configuration registers
    // ************************************************************
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            ctrl_reg  <= `BPAS_CTRL_RST;
            blank_reg <= '0;
        end else if (ce_i && wr_en) begin
            if (paddr_i == `BPAS_OFS_CTRL) begin
                ctrl_reg <= pwdata_i[2:0];
            end
            if (paddr_i == `BPAS_OFS_BLANK) begin
                blank_reg <= pwdata_i[NBEAMS-1:0];
            end
        end
    end

    // ************************************************************
    // beam evaluation
    // ************************************************************
    bpas_beam_eval #(.NBEAMS(NBEAMS), .VW(VW)) u_eval (
        .mclk_i  (mclk_i),
        .reset_i (reset_i),
        .ce_i    (ce_i),
        .beams_i (beams_i),
        .blank_i (blank_reg),
        .res     (ev.prod)
    );

    // ************************************************************
    // mode selection
    // ************************************************************
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            cand_reg <= BPAS_MODE_POS;
            mode_reg <= BPAS_MODE_POS;
        end else if (ce_i) begin
            if (cmd[`BPAS_CMD_UP]) begin
                case (cand_reg)
                    BPAS_MODE_POS:  cand_reg <= BPAS_MODE_SIZE;
                    BPAS_MODE_SIZE: cand_reg <= BPAS_MODE_WEB;
                    default:        cand_reg <= BPAS_MODE_POS;
                endcase
            end else if (cmd[`BPAS_CMD_DOWN]) begin
                case (cand_reg)
                    BPAS_MODE_WEB:  cand_reg <= BPAS_MODE_SIZE;
                    BPAS_MODE_SIZE: cand_reg <= BPAS_MODE_POS;
                    default:        cand_reg <= BPAS_MODE_WEB;
                endcase
            end
            if (cmd[`BPAS_CMD_ENTER]) begin
                mode_reg <= cand_reg;
            end
        end
    end

    assign mode_o          = mode_reg;
    assign range_current_o = ctrl_reg[`BPAS_CTRL_RANGE];

    // ************************************************************
    // teach and trim
    // ************************************************************
    logic          pos_mode;
    logic [VW-1:0] val_now;

    assign pos_mode = mode_reg != BPAS_MODE_WEB;
    assign val_now  = (mode_reg == BPAS_MODE_SIZE) ? ev.count :
                      ctrl_reg[`BPAS_CTRL_BOTTOM] ? ev.bot_idx :
                      ev.top_idx;

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            low_reg        <= '0;
            high_reg       <= VW'(NBEAMS - 1);
            pos_taught_reg <= 1'b0;
        end else if (ce_i) begin
            if (pos_mode && cmd[`BPAS_CMD_T_FULL]) begin
                high_reg       <= val_now;
                pos_taught_reg <= 1'b1;
            end else if (pos_taught_reg && pos_mode) begin
                if (cmd[`BPAS_CMD_HIGH_INC] && high_reg != VW'(NBEAMS))
                    high_reg <= high_reg + VW'(1);
                else if (cmd[`BPAS_CMD_HIGH_DEC] && high_reg != '0)
                    high_reg <= high_reg - VW'(1);
            end
            if (pos_mode && cmd[`BPAS_CMD_T_ZERO]) begin
                low_reg        <= val_now;
                pos_taught_reg <= 1'b1;
            end else if (pos_taught_reg && pos_mode) begin
                if (cmd[`BPAS_CMD_LOW_INC] && low_reg != VW'(NBEAMS))
                    low_reg <= low_reg + VW'(1);
                else if (cmd[`BPAS_CMD_LOW_DEC] && low_reg != '0)
                    low_reg <= low_reg - VW'(1);
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            ref_top_reg    <= '0;
            ref_bot_reg    <= '0;
            web_taught_reg <= 1'b0;
            step_reg       <= `BPAS_STEP_RST;
        end else if (ce_i) begin
            if (!pos_mode && cmd[`BPAS_CMD_T_MID]) begin
                ref_top_reg    <= ev.top_idx;
                ref_bot_reg    <= ev.bot_idx;
                web_taught_reg <= 1'b1;
            end else if (web_taught_reg && !pos_mode) begin
                if (cmd[`BPAS_CMD_STEP_INC] && step_reg != `BPAS_STEP_MAX)
                    step_reg <= step_reg + SW'(1);
                else if (cmd[`BPAS_CMD_STEP_DEC] &&
                         step_reg != `BPAS_STEP_MIN)
                    step_reg <= step_reg - SW'(1);
            end
        end
    end

    // ************************************************************
    // span selection
    // ************************************************************
    logic [CW-1:0] c_min;
    logic [CW-1:0] c_max;
    logic [CW-1:0] c_mid;

    assign c_min = ctrl_reg[`BPAS_CTRL_RANGE] ? `BPAS_I_MIN :
                   `BPAS_V_MIN;
    assign c_max = ctrl_reg[`BPAS_CTRL_RANGE] ? `BPAS_I_MAX :
                   `BPAS_V_MAX;
    assign c_mid = ctrl_reg[`BPAS_CTRL_RANGE] ? `BPAS_I_MID :
                   `BPAS_V_MID;

    // ************************************************************
    // position and size interpolation
    // ************************************************************
    logic [VW:0]   num;
    logic [VW:0]   den;
    logic [VW-1:0] num_m;
    logic [VW-1:0] den_m;
    logic [NW-1:0] dividend;
    logic [NW-1:0] quot;
    logic [CW-1:0] span;
    logic [1:0]    sel_next;
    logic [1:0]    sel_reg;
    logic [CW-1:0] min_reg;
    logic [CW-1:0] max_reg;
    logic          div_busy;
    logic          div_done;

    assign num      = {1'b0, val_now} - {1'b0, low_reg};
    assign den      = {1'b0, high_reg} - {1'b0, low_reg};
    assign num_m    = mag(num);
    assign den_m    = mag(den);
    assign span     = c_max - c_min;
    assign dividend = NW'(num_m * span);

    always_comb begin
        sel_next = 2'd0;
        if (den == '0) begin
            sel_next = num[VW] ? 2'd1 : 2'd2;
        end else if (num == '0 || num[VW] != den[VW]) begin
            sel_next = 2'd1;
        end else if (num_m >= den_m) begin
            sel_next = 2'd2;
        end
    end

    bpas_div #(.NW(NW), .DW(VW)) u_div (
        .mclk_i     (mclk_i),
        .reset_i    (reset_i),
        .ce_i       (ce_i),
        .start_i    (!div_busy),
        .dividend_i (dividend),
        .divisor_i  (den_m),
        .busy_o     (div_busy),
        .done_o     (div_done),
        .quot_o     (quot)
    );

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            sel_reg      <= 2'd1;
            min_reg      <= `BPAS_V_MIN;
            max_reg      <= `BPAS_V_MAX;
            pos_code_reg <= `BPAS_V_MIN;
        end else if (ce_i) begin
            if (!div_busy) begin
                sel_reg <= sel_next;
                min_reg <= c_min;
                max_reg <= c_max;
            end
            if (div_done) begin
                case (sel_reg)
                    2'd1:    pos_code_reg <= min_reg;
                    2'd2:    pos_code_reg <= max_reg;
                    default: pos_code_reg <= min_reg + quot[CW-1:0];
                endcase
            end
        end
    end

    // ************************************************************
    // web edge output
    // ************************************************************
    logic signed [VW+2:0]    d_top;
    logic signed [VW+2:0]    d_bot;
    logic signed [VW+2:0]    delta;
    logic signed [SW+VW+2:0] prod;
    logic signed [SW+VW+3:0] web_sum;
    logic [CW-1:0]           web_code;

    assign d_top = $signed({3'b000, ev.top_idx}) -
                   $signed({3'b000, ref_top_reg});
    assign d_bot = $signed({3'b000, ev.bot_idx}) -
                   $signed({3'b000, ref_bot_reg});
    // dependent edge: top stays at the field top, bottom edge counts
    assign delta = ctrl_reg[`BPAS_CTRL_WEBDEP] ? d_bot :
                   d_bot - d_top;
    assign prod    = step_reg * delta;
    assign web_sum = $signed({{(SW+VW+4-CW){1'b0}}, c_mid}) +
                     (SW+VW+4)'(prod);

    always_comb begin
        if (web_sum < $signed({{(SW+VW+4-CW){1'b0}}, c_min}))
            web_code = c_min;
        else if (web_sum > $signed({{(SW+VW+4-CW){1'b0}}, c_max}))
            web_code = c_max;
        else
            web_code = web_sum[CW-1:0];
    end

    // ************************************************************
    // output code
    // ************************************************************
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            code_reg <= `BPAS_V_MIN;
        end else if (ce_i) begin
            if (!pos_mode)
                code_reg <= web_code;
            else
                code_reg <= pos_code_reg;
        end
    end

    assign analog_code_o = code_reg;

endmodule : bpas_top

// >>> pkg/bpas_consts.svh
// constants of the beam position analog scaler
`ifndef BPAS_CONSTS_SVH
`define BPAS_CONSTS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define BPAS_OFS_CTRL    8'h00
`define BPAS_OFS_CMD     8'h04
`define BPAS_OFS_BLANK   8'h08
`define BPAS_OFS_LOW     8'h0C
`define BPAS_OFS_HIGH    8'h10
`define BPAS_OFS_STEP    8'h14
`define BPAS_OFS_REF     8'h18
`define BPAS_OFS_STATUS  8'h1C
`define BPAS_OFS_CODE    8'h20

// ****************************************************************
// field positions
// ****************************************************************
`define BPAS_CTRL_RANGE   0
`define BPAS_CTRL_BOTTOM  1
`define BPAS_CTRL_WEBDEP  2
`define BPAS_CMD_UP       0
`define BPAS_CMD_DOWN     1
`define BPAS_CMD_ENTER    2
`define BPAS_CMD_T_FULL   3
`define BPAS_CMD_T_ZERO   4
`define BPAS_CMD_T_MID    5
`define BPAS_CMD_LOW_INC  6
`define BPAS_CMD_LOW_DEC  7
`define BPAS_CMD_HIGH_INC 8
`define BPAS_CMD_HIGH_DEC 9
`define BPAS_CMD_STEP_INC 10
`define BPAS_CMD_STEP_DEC 11

// ****************************************************************
// reset values and output codes
// ****************************************************************
`define BPAS_CTRL_RST  3'h0
`define BPAS_STEP_RST  16'h0020
`define BPAS_STEP_MAX  16'h7FFF
`define BPAS_STEP_MIN  16'h8001
`define BPAS_CODE_W    12
`define BPAS_V_MIN     12'h000
`define BPAS_V_MID     12'h7FF
`define BPAS_V_MAX     12'hFFF
`define BPAS_I_MIN     12'h333
`define BPAS_I_MID     12'h999
`define BPAS_I_MAX     12'hFFF

`endif

// >>> pkg/bpas_pkg.sv
// types of the beam position analog scaler
package bpas_pkg;

    // ************************************************************
    // teach modes and divider states
    // ************************************************************
    typedef enum logic [1:0] {
        BPAS_MODE_POS  = 2'b00,
        BPAS_MODE_SIZE = 2'b01,
        BPAS_MODE_WEB  = 2'b10
    } bpas_mode_t;

    typedef enum logic {
        BPAS_DIV_IDLE = 1'b0,
        BPAS_DIV_RUN  = 1'b1
    } bpas_div_state_t;

endpackage : bpas_pkg

// >>> pkg/bpas_eval_if.sv
// carrier of beam evaluation results
`timescale 1ns/1ps
interface bpas_eval_if #(parameter int VW = 6);
    logic [VW-1:0] top_idx;
    logic [VW-1:0] bot_idx;
    logic [VW-1:0] count;
    logic          any;

    modport prod (output top_idx, output bot_idx, output count,
                  output any);
    modport cons (input top_idx, input bot_idx, input count,
                  input any);
endinterface : bpas_eval_if

// >>> logic/bpas_beam_eval.sv
// beam pattern evaluation: edges and count of interrupted beams
`timescale 1ns/1ps
module bpas_beam_eval #(
    parameter int NBEAMS = 32,
    parameter int VW     = 6
) (
    input  wire logic              mclk_i,
    input  wire logic              reset_i,
    input  wire logic              ce_i,
    input  wire logic [NBEAMS-1:0] beams_i,
    input  wire logic [NBEAMS-1:0] blank_i,
    bpas_eval_if.prod              res
);
    import bpas_pkg::*;

    logic [NBEAMS-1:0] eff;
    logic [VW-1:0]     top_next;
    logic [VW-1:0]     bot_next;
    logic [VW-1:0]     cnt_next;

    assign eff = beams_i & ~blank_i;

    always_comb begin
        top_next = '0;
        bot_next = '0;
        cnt_next = '0;
        for (int i = 0; i < NBEAMS; i++) begin
            if (eff[i]) begin
                top_next = VW'(i);
                cnt_next = cnt_next + VW'(1);
            end
        end
        for (int i = NBEAMS - 1; i >= 0; i--) begin
            if (eff[i]) begin
                bot_next = VW'(i);
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            res.top_idx <= '0;
            res.bot_idx <= '0;
            res.count   <= '0;
            res.any     <= 1'b0;
        end else if (ce_i) begin
            res.top_idx <= top_next;
            res.bot_idx <= bot_next;
            res.count   <= cnt_next;
            res.any     <= |eff;
        end
    end
endmodule : bpas_beam_eval

// >>> logic/bpas_div.sv
// restoring serial divider for the interpolation
`timescale 1ns/1ps
module bpas_div #(
    parameter int NW = 18,
    parameter int DW = 6
) (
    input  wire logic          mclk_i,
    input  wire logic          reset_i,
    input  wire logic          ce_i,
    input  wire logic          start_i,
    input  wire logic [NW-1:0] dividend_i,
    input  wire logic [DW-1:0] divisor_i,
    output logic               busy_o,
    output logic               done_o,
    output logic [NW-1:0]      quot_o
);
    import bpas_pkg::*;

    localparam int CW = $clog2(NW) + 1;

    bpas_div_state_t state_reg;
    logic [CW-1:0]   cnt_reg;
    logic [NW-1:0]   dvd_reg;
    logic [DW-1:0]   dsr_reg;
    logic [DW:0]     rem_reg;
    logic [DW:0]     rem_sh;
    logic            fits;

    assign rem_sh = {rem_reg[DW-1:0], dvd_reg[NW-1]};
    assign fits   = rem_sh >= {1'b0, dsr_reg};
    assign busy_o = state_reg == BPAS_DIV_RUN;

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            state_reg <= BPAS_DIV_IDLE;
            cnt_reg   <= '0;
            dvd_reg   <= '0;
            dsr_reg   <= '0;
            rem_reg   <= '0;
            quot_o    <= '0;
            done_o    <= 1'b0;
        end else if (ce_i) begin
            done_o <= 1'b0;
            case (state_reg)
                BPAS_DIV_IDLE: begin
                    if (start_i) begin
                        dvd_reg   <= dividend_i;
                        dsr_reg   <= divisor_i;
                        rem_reg   <= '0;
                        cnt_reg   <= '0;
                        state_reg <= BPAS_DIV_RUN;
                    end
                end
                BPAS_DIV_RUN: begin
                    rem_reg <= fits ? rem_sh - {1'b0, dsr_reg} : rem_sh;
                    dvd_reg <= {dvd_reg[NW-2:0], fits};
                    cnt_reg <= cnt_reg + CW'(1);
                    if (cnt_reg == CW'(NW - 1)) begin
                        quot_o    <= {dvd_reg[NW-2:0], fits};
                        done_o    <= 1'b1;
                        state_reg <= BPAS_DIV_IDLE;
                    end
                end
                default: state_reg <= BPAS_DIV_IDLE;
            endcase
        end
    end
endmodule : bpas_div

// >>> test/bpas_beam_model.sv
// receiver array model: one run of interrupted beams
`timescale 1ns/1ps
module bpas_beam_model (
    input  wire logic        mclk_i,
    input  wire logic [5:0]  lo_i,
    input  wire logic [5:0]  hi_i,
    output logic      [31:0] beams_o
);
    always_ff @(posedge mclk_i) begin
        for (int i = 0; i < 32; i++) begin
            beams_o[i] <= (6'(i) >= lo_i) && (6'(i) <= hi_i);
        end
    end
endmodule : bpas_beam_model

// >>> test/bpas_chk.sv
// port assertions of the scaler
`timescale 1ns/1ps
`include "bpas_consts.svh"
module bpas_chk (
    input wire logic                 mclk_i,
    input wire logic                 reset_i,
    input wire logic                 ce_i,
    input wire logic                 psel_i,
    input wire logic                 penable_i,
    input wire logic                 pwrite_i,
    input wire logic [7:0]           paddr_i,
    input wire logic [31:0]          prdata_o,
    input wire logic                 pready_o,
    input wire logic                 pslverr_o,
    input wire logic [11:0]          analog_code_o,
    input wire logic                 range_current_o,
    input wire bpas_pkg::bpas_mode_t mode_o
);
    import bpas_pkg::*;
    logic [6:0] hold_cnt;
    logic       rng_prev;
    wire wr_done = psel_i && penable_i && pwrite_i && pready_o;
    always_ff @(posedge mclk_i) begin
        rng_prev <= range_current_o;
        if (reset_i || rng_prev != range_current_o) hold_cnt <= 7'h00;
        else if (hold_cnt != 7'h7F) hold_cnt <= hold_cnt + 7'h01;
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    sequence s_setup; psel_i && !penable_i && ce_i; endsequence
    sequence s_access; psel_i && penable_i && ce_i; endsequence
    a_err_ready: assert property (pslverr_o |-> pready_o)
        else $error("error flag without ready");
    a_access_ready: assert property (s_setup ##1 s_access |-> pready_o)
        else $error("no ready in first access cycle");
    a_ready_ce: assert property (!ce_i |-> !pready_o)
        else $error("ready while clock enable low");
    a_unmapped_err: assert property (psel_i && penable_i && pready_o
        && paddr_i > 8'h20 |-> pslverr_o) else $error("no error flag");
    a_cmd_rdzero: assert property (psel_i && penable_i && pready_o
        && !pwrite_i && paddr_i == `BPAS_OFS_CMD |-> prdata_o == 32'h0)
        else $error("command read not zero");
    a_mode_commit: assert property (!$stable(mode_o) |->
        $past(wr_done && paddr_i == `BPAS_OFS_CMD))
        else $error("mode changed without command");
    a_mode_legal: assert property (mode_o != 2'h3)
        else $error("illegal mode");
    a_range_commit: assert property (!$stable(range_current_o) |->
        $past(wr_done && paddr_i == `BPAS_OFS_CTRL))
        else $error("range changed without control write");
    a_span_current: assert property (range_current_o &&
        hold_cnt >= 7'h40 |-> analog_code_o >= `BPAS_I_MIN)
        else $error("code below current span");
endmodule : bpas_chk
bind bpas_top bpas_chk bpas_chk_inst (.mclk_i, .reset_i, .ce_i, .psel_i,
    .penable_i, .pwrite_i, .paddr_i, .prdata_o, .pready_o, .pslverr_o,
    .analog_code_o, .range_current_o, .mode_o);

// >>> test/beam_position_analog_scaler_test.sv
// self-checking bench of the scaler
`timescale 1ns/1ps
`include "bpas_consts.svh"
module beam_position_analog_scaler_test;
    import bpas_pkg::*;
    logic        mclk_i = 1'h0, reset_i = 1'h1, ce_i = 1'h1;
    logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q, beams;
    logic        pready, pslverr, rng, e;
    logic [11:0] code;
    logic [5:0]  lo = 6'h3F, hi = 6'h00;
    bpas_mode_t  mode;
    int          n_fail = 0, samples_checked = 0;
    always #12.5 mclk_i = ~mclk_i;
    bpas_beam_model bpas_beam_model_inst (.mclk_i, .lo_i(lo), .hi_i(hi),
        .beams_o(beams));
    bpas_top bpas_top_inst (.mclk_i, .reset_i, .ce_i, .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .beams_i(beams), .analog_code_o(code),
        .range_current_o(rng), .mode_o(mode));
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string nm, input logic [31:0] x, g);
        samples_checked++;
        if (g !== x) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, x, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge mclk_i);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk_i);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge mclk_i);
            n++;
        end while (pready !== 1'h1 && n < 16);
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (n >= 16) chk("pready", 32'h1, 32'h0);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'h0, a, 32'h0);
        chk("register", x, q);
    endtask : rd
    task automatic cmd(input int b);
        wr(`BPAS_OFS_CMD, 32'h1 << b);
        repeat (2) @(posedge mclk_i);
    endtask : cmd
    task automatic run(input logic [5:0] l, h);
        @(posedge mclk_i);
        lo <= l;
        hi <= h;
        repeat (60) @(posedge mclk_i);
    endtask : run
    task automatic see(input logic [5:0] l, h, input logic [11:0] x);
        run(l, h);
        chk("code", {20'h0, x}, {20'h0, code});
    endtask : see
    initial begin
        repeat (6) @(posedge mclk_i);
        reset_i <= 1'h0;
        rd(`BPAS_OFS_STEP, 32'h20);
        rd(`BPAS_OFS_HIGH, 32'h1F);
        apb(1'h0, 8'h40, 32'h0);
        chk("slverr", 32'h1, {31'h0, e});
        rd(`BPAS_OFS_CMD, 32'h0);
        cmd(`BPAS_CMD_LOW_INC);
        rd(`BPAS_OFS_LOW, 32'h0);
        run(6'h03, 6'h0A);
        cmd(`BPAS_CMD_T_ZERO);
        run(6'h03, 6'h14);
        cmd(`BPAS_CMD_T_FULL);
        rd(`BPAS_OFS_LOW, 32'h0A);
        rd(`BPAS_OFS_HIGH, 32'h14);
        see(6'h03, 6'h0F, 12'h7FF);
        see(6'h03, 6'h19, 12'hFFF);
        see(6'h03, 6'h05, 12'h000);
        wr(`BPAS_OFS_BLANK, 32'h8000);
        see(6'h03, 6'h0F, 12'h666);
        wr(`BPAS_OFS_BLANK, 32'h0);
        wr(`BPAS_OFS_CTRL, 32'h2);
        see(6'h0F, 6'h19, 12'h7FF);
        cmd(`BPAS_CMD_LOW_INC);
        cmd(`BPAS_CMD_HIGH_DEC);
        rd(`BPAS_OFS_LOW, 32'h0B);
        rd(`BPAS_OFS_HIGH, 32'h13);
        see(6'h0F, 6'h19, 12'h7FF);
        wr(`BPAS_OFS_CTRL, 32'h3);
        see(6'h0B, 6'h19, 12'h333);
        chk("range", 32'h1, {31'h0, rng});
        see(6'h13, 6'h19, 12'hFFF);
        wr(`BPAS_OFS_CTRL, 32'h0);
        @(posedge mclk_i);
        ce_i <= 1'h0;
        repeat (3) @(posedge mclk_i);
        ce_i <= 1'h1;
        cmd(`BPAS_CMD_UP);
        chk("mode", 32'h0, {30'h0, mode});
        cmd(`BPAS_CMD_ENTER);
        chk("mode", 32'h1, {30'h0, mode});
        run(6'h00, 6'h03);
        cmd(`BPAS_CMD_T_ZERO);
        run(6'h00, 6'h0B);
        cmd(`BPAS_CMD_T_FULL);
        see(6'h00, 6'h07, 12'h7FF);
        cmd(`BPAS_CMD_DOWN);
        cmd(`BPAS_CMD_DOWN);
        cmd(`BPAS_CMD_ENTER);
        chk("mode", 32'h2, {30'h0, mode});
        run(6'h05, 6'h14);
        cmd(`BPAS_CMD_T_MID);
        see(6'h05, 6'h14, 12'h7FF);
        rd(`BPAS_OFS_REF, 32'h00050014);
        see(6'h05, 6'h16, 12'h7BF);
        see(6'h07, 6'h14, 12'h83F);
        cmd(`BPAS_CMD_STEP_DEC);
        rd(`BPAS_OFS_STEP, 32'h1F);
        cmd(`BPAS_CMD_LOW_INC);
        rd(`BPAS_OFS_LOW, 32'h04);
        wr(`BPAS_OFS_CTRL, 32'h4);
        see(6'h05, 6'h16, 12'h7FF);
        tally_and_finish;
    end
    initial begin
        repeat (10000) @(posedge mclk_i);
        n_fail++;
        tally_and_finish;
    end
endmodule : beam_position_analog_scaler_test
